// [src/input_keeper.sv]
// Input keeper latch: tracks the pins while running, keeps the last level on hold
`timescale 1ns/100ps
`include "sleep_hold_defs.svh"
module input_keeper (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // Carrier
    sleep_hold_if.latch kif
);
    import sleep_hold_pkg::*;

    io_word_t held;
    io_word_t next_held;

    // ****************************************
    // Keeper register
    // ****************************************
    // While held the pins are blocked, so the stored level is what the logic sees
    always_comb begin
        next_held = kif.hold ? held : kif.live;
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            held <= `SH_IN_RST;
        end else begin
            held <= next_held;
        end
    end

    assign kif.held = held;

    // ****************************************
    // Checks
    // ****************************************
    a_keeper_holds_level: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        kif.hold |=> held == $past(held))
        else $error("Keeper level changed during hold");
endmodule

// [src/pin_controlled_sleep_hold.sv]
// Small programmable logic array with a pin-controlled sleep hold
`timescale 1ns/100ps
`include "sleep_hold_defs.svh"
module pin_controlled_sleep_hold #(
    parameter bit SLEEP_EN = 1'b1
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // Sleep control
    input wire logic sleep_control_pin_i,
    output logic hold_o,
    // Array inputs
    input wire sleep_hold_pkg::io_word_t data_i,
    input wire logic gclk_i,
    input wire logic oe_i,
    // Output pins
    output sleep_hold_pkg::io_word_t pin_o,
    output sleep_hold_pkg::io_word_t pin_oe_o,
    // Input keepers
    output logic keep_en_o,
    output sleep_hold_pkg::io_word_t keep_level_o
);
    import sleep_hold_pkg::*;

    localparam int wake_lim = `SH_WAKE_MAX_CYCLES;

    // ****************************************
    // Decode
    // ****************************************
    // Sleep decoding is used by the state logic and the freeze gate
    function automatic logic sleep_active(input logic en, input logic pin);
        sleep_active = en & pin;
    endfunction

    hold_state_e state;
    hold_state_e next_state;
    logic frozen;
    logic gclk_prev;
    logic next_gclk_prev;
    logic gclk_rise;
    logic in_gclk;
    logic in_oe;
    logic in_pin;
    io_word_t in_data;
    mc_word_t mc;
    mc_word_t next_mc;
    mc_word_t mc_d;
    io_word_t out_data;
    io_word_t next_out_data;
    logic out_oe;
    logic next_out_oe;
    io_word_t comb_term;

    // Frozen from the very edge at which the pin is seen high
    assign frozen = sleep_active(SLEEP_EN, sleep_control_pin_i);

    // ****************************************
    // Input keepers
    // ****************************************
    sleep_hold_if kif ();
    io_word_t keep_live;

    // Only the data pins pass the keeper; the control pins get their own gated flops
    assign keep_live = data_i;
    assign kif.hold = frozen;
    assign kif.live = keep_live;

    input_keeper u_keeper (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .kif(kif)
    );

    // Control pins are kept in separate flops; gated the same way as the data keepers
    logic ctl_gclk;
    logic ctl_oe;
    logic ctl_pin;
    logic next_ctl_gclk;
    logic next_ctl_oe;
    logic next_ctl_pin;

    always_comb begin
        next_ctl_gclk = frozen ? ctl_gclk : gclk_i;
        next_ctl_oe = frozen ? ctl_oe : oe_i;
        next_ctl_pin = frozen ? ctl_pin : sleep_control_pin_i;
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            ctl_gclk <= 1'b0;
            ctl_oe <= `SH_OE_RST;
            ctl_pin <= 1'b0;
        end else begin
            ctl_gclk <= next_ctl_gclk;
            ctl_oe <= next_ctl_oe;
            ctl_pin <= next_ctl_pin;
        end
    end

    assign in_data = kif.held;
    assign in_gclk = ctl_gclk;
    assign in_oe = ctl_oe;
    assign in_pin = ctl_pin;

    // ****************************************
    // Hold state
    // ****************************************
    // Capture relies on the partner holding inputs steady around the pin edge
    always_comb begin
        case (state)
            ST_RUN: next_state = frozen ? ST_HOLD : ST_RUN;
            ST_HOLD: next_state = frozen ? ST_HOLD : ST_RUN;
            default: next_state = ST_RUN;
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            state <= ST_RUN;
        end else begin
            state <= next_state;
        end
    end

    // ****************************************
    // Macrocell array
    // ****************************************
    // Edge detect on the kept clock; the kept level stops a false edge at wake
    assign gclk_rise = in_gclk & ~gclk_prev;

    generate
        for (genvar k = 0; k < `SH_MC_W; k++) begin : g_mc
            if (k == 0) begin : g_first
                // With sleep on, the pin feeds nothing; buried feedback stays in use
                assign mc_d[k] = in_data[k] ^ (SLEEP_EN ? mc[`SH_MC_W-1] : in_pin);
            end else begin : g_rest
                assign mc_d[k] = in_data[k] ^ mc[k-1];
            end
        end
    endgenerate

    // Registers hold their state while frozen; no reset is applied on wake
    always_comb begin
        next_gclk_prev = frozen ? gclk_prev : in_gclk;
        next_mc = mc;
        if (!frozen && gclk_rise) begin
            next_mc = mc_d;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            gclk_prev <= 1'b0;
            mc <= `SH_MC_RST;
        end else begin
            gclk_prev <= next_gclk_prev;
            mc <= next_mc;
        end
    end

    // ****************************************
    // Output pins
    // ****************************************
    // Low half registered, high half a combinational term, both land in output flops
    assign comb_term = {in_data[7:4] & mc[7:4], 4'h0};

    always_comb begin
        next_out_data = out_data;
        next_out_oe = out_oe;
        if (!frozen) begin
            next_out_data = {comb_term[7:4], mc[3:0]};
            next_out_oe = in_oe;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            out_data <= `SH_OUT_RST;
            out_oe <= `SH_OE_RST;
        end else begin
            out_data <= next_out_data;
            out_oe <= next_out_oe;
        end
    end

    assign pin_o = out_data;
    assign pin_oe_o = {`SH_IO_W{out_oe}};
    assign hold_o = (state == ST_HOLD);
    assign keep_en_o = 1'b1;
    assign keep_level_o = kif.held;

    // ****************************************
    // Checks
    // ****************************************
    a_enter_on_pin: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        sleep_control_pin_i && SLEEP_EN |=> hold_o)
        else $error("Hold not entered after sleep pin high");
    a_off_never_holds: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        !SLEEP_EN |-> !hold_o)
        else $error("Hold entered with sleep option off");
    a_hold_freezes_state: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        hold_o && $past(hold_o) |-> $stable(mc))
        else $error("Internal state changed during hold");
    a_hold_keeps_outputs: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        hold_o && $past(hold_o) |-> $stable(pin_o))
        else $error("Output data changed during hold");
    a_hold_keeps_tristate: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        hold_o && $past(pin_oe_o) == 8'h00 |-> pin_oe_o == 8'h00)
        else $error("Tri-stated output enabled during hold");
    a_hold_blocks_clock: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        frozen && $rose(gclk_i) |=> mc == $past(mc))
        else $error("Clock reached the array during hold");
    a_keepers_active: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        hold_o |-> keep_en_o && keep_level_o == $past(keep_level_o))
        else $error("Keeper not active during hold");
    a_pin_not_logic: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        SLEEP_EN && !frozen && gclk_rise |=> mc[0] == ($past(in_data[0]) ^ $past(mc[7])))
        else $error("Sleep pin reached the logic array");
    a_wake_bound: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        hold_o && !sleep_control_pin_i |-> ##[1:wake_lim] !hold_o)
        else $error("Wake took longer than allowed");
    a_resume_no_reset: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        $fell(hold_o) |-> mc == ($past(gclk_rise) ? $past(mc_d) : $past(mc))
            && pin_o == {$past(comb_term[7:4]), $past(mc[3:0])})
        else $error("State lost on leaving hold");

    c_enter_hold: cover property (@(posedge clock_i) disable iff (!rst_n_i) $rose(hold_o));
    c_leave_hold: cover property (@(posedge clock_i) disable iff (!rst_n_i) $fell(hold_o));
    c_clock_in_hold: cover property (@(posedge clock_i) disable iff (!rst_n_i)
        hold_o && $rose(gclk_i));
    c_tristate_hold: cover property (@(posedge clock_i) disable iff (!rst_n_i)
        hold_o && pin_oe_o == 8'h00);
endmodule

// [src/sleep_hold_defs.svh]
// Constant definitions for the pin-controlled sleep hold block
`ifndef SLEEP_HOLD_DEFS_SVH
`define SLEEP_HOLD_DEFS_SVH

// ****************************************
// Widths
// ****************************************
`define SH_IO_W 8
`define SH_MC_W 8
`define SH_REG_OUT_W 4

// ****************************************
// Reset values
// ****************************************
`define SH_MC_RST 8'h00
`define SH_OUT_RST 8'h00
`define SH_OE_RST 1'b0
`define SH_IN_RST 8'h00

// ****************************************
// Timing
// ****************************************
`define SH_CLK_PERIOD_NS 100
// Partner setup before the sleep pin rises (least time, rounds up)
`define SH_SETUP_NS 15
`define SH_SETUP_CYCLES ((`SH_SETUP_NS + `SH_CLK_PERIOD_NS - 1) / `SH_CLK_PERIOD_NS)
// Partner hold after the sleep pin rises (longest time, rounds down, at least one)
`define SH_HOLD_NS 25
`define SH_HOLD_CYCLES ((`SH_HOLD_NS / `SH_CLK_PERIOD_NS) < 1 ? 1 : (`SH_HOLD_NS / `SH_CLK_PERIOD_NS))
// Wake to valid operation (longest time, rounds down)
`define SH_WAKE_MAX_NS 1000
`define SH_WAKE_MAX_CYCLES (`SH_WAKE_MAX_NS / `SH_CLK_PERIOD_NS)

`endif

// [src/sleep_hold_if.sv]
// Carrier between the main block and its input keeper latch
`timescale 1ns/100ps
interface sleep_hold_if;
    import sleep_hold_pkg::*;

    // ****************************************
    // Signals
    // ****************************************
    logic hold;
    io_word_t live;
    io_word_t held;

    modport owner (
        output hold,
        output live,
        input held
    );
    modport latch (
        input hold,
        input live,
        output held
    );
endinterface

// [src/sleep_hold_pkg.sv]
// Types shared by the sleep hold block
package sleep_hold_pkg;
    `include "sleep_hold_defs.svh"

    // ****************************************
    // Types
    // ****************************************
    typedef logic [`SH_IO_W-1:0] io_word_t;
    typedef logic [`SH_MC_W-1:0] mc_word_t;
    typedef enum logic {
        ST_RUN,
        ST_HOLD
    } hold_state_e;
endpackage

// [testbench/sys_logic_model.sv]
// System logic model that drives the array inputs and the sleep pin
`timescale 1ns/100ps
module sys_logic_model (
    // Clock
    input wire logic clock_i,
    // Driven pins
    output sleep_hold_pkg::io_word_t data_o,
    output logic gclk_o,
    output logic oe_o,
    output logic sleep_o
);
    import sleep_hold_pkg::*;

    // All pins idle low from time zero
    initial begin
        data_o = 8'h00;
        gclk_o = 1'b0;
        oe_o = 1'b0;
        sleep_o = 1'b0;
    end

    // Data and enable change only just after a rising edge
    task automatic drive(input io_word_t d, input logic oe);
        @(posedge clock_i);
        data_o <= d;
        oe_o <= oe;
    endtask

    // One array clock pulse, high and low one cycle each
    task automatic pulse();
        @(posedge clock_i);
        gclk_o <= 1'b1;
        @(posedge clock_i);
        gclk_o <= 1'b0;
    endtask

    // Inputs settle a cycle before the pin moves and stay a cycle after it
    task automatic sleep(input logic lvl);
        @(posedge clock_i);
        sleep_o <= lvl;
        @(posedge clock_i);
    endtask
endmodule

// [testbench/tb.sv]
// Self-checking bench for the sleep hold block
`timescale 1ns/100ps
`include "sleep_hold_defs.svh"
module tb;
    import sleep_hold_pkg::*;

    // ****************************************
    // Signals
    // ****************************************
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    io_word_t data, pin, pin_oe, keep_level, mc, s_pin, s_keep, plain_pin;
    logic gclk, oe, sleep, hold, keep_en, plain_hold;
    int error_cnt = 0;
    int checks_done = 0;
    int cycles = 0;

    // Partner and the block, plus a build without the sleep option
    sys_logic_model u_sys (.clock_i(clock_i), .data_o(data), .gclk_o(gclk), .oe_o(oe),
        .sleep_o(sleep));
    pin_controlled_sleep_hold u_dut (.clock_i(clock_i), .rst_n_i(rst_n_i),
        .sleep_control_pin_i(sleep), .hold_o(hold), .data_i(data), .gclk_i(gclk), .oe_i(oe),
        .pin_o(pin), .pin_oe_o(pin_oe), .keep_en_o(keep_en), .keep_level_o(keep_level));
    pin_controlled_sleep_hold #(.SLEEP_EN(1'b0)) u_plain (.clock_i(clock_i),
        .rst_n_i(rst_n_i), .sleep_control_pin_i(sleep), .hold_o(plain_hold), .data_i(data),
        .gclk_i(gclk), .oe_i(oe), .pin_o(plain_pin), .pin_oe_o(), .keep_en_o(),
        .keep_level_o());

    // Clock, and a cycle ceiling so a hang still reaches the verdict
    initial forever #50 clock_i = ~clock_i;
    always @(posedge clock_i) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            error_cnt++;
            tally_and_finish();
        end
    end

    // ****************************************
    // Helpers
    // ****************************************
    task automatic check(input string what, input io_word_t seen, input io_word_t exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Samples are taken on the falling edge, well clear of input changes
    task automatic ticks(input int n);
        repeat (n) @(negedge clock_i);
    endtask

    // Reference of one array clock: rotate and mix in the data
    function automatic io_word_t nmc(input io_word_t m, input io_word_t d);
        return d ^ {m[6:0], m[7]};
    endfunction

    function automatic io_word_t xpin(input io_word_t m, input io_word_t d);
        return {d[7:4] & m[7:4], m[3:0]};
    endfunction

    // Without the sleep option the pin itself is mixed into the first cell
    function automatic io_word_t pmc(input io_word_t m, input io_word_t d, input logic p);
        return d ^ {m[6:0], p};
    endfunction

    task automatic tally_and_finish();
        $display("errors %0d checks %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        ticks(1);
        check("pin", pin, 8'h00);
        check("pin_oe", pin_oe, 8'h00);
        check("hold", {7'h00, hold}, 8'h00);
        check("keep_en", {7'h00, keep_en}, 8'h01);
        check("keep_level", keep_level, 8'h00);
    endtask

    task automatic t_run();
        u_sys.drive(8'ha5, 1'b1);
        u_sys.pulse();
        ticks(5);
        mc = nmc(mc, 8'ha5);
        check("run pin", pin, xpin(mc, 8'ha5));
        check("run pin_oe", pin_oe, 8'hff);
        check("run keep", keep_level, 8'ha5);
    endtask

    // Inputs and clocks move during hold; nothing may follow them
    task automatic t_hold();
        u_sys.sleep(1'b1);
        ticks(2);
        check("hold up", {7'h00, hold}, 8'h01);
        s_pin = pin;
        s_keep = keep_level;
        u_sys.drive(8'h3c, 1'b0);
        u_sys.pulse();
        u_sys.pulse();
        ticks(4);
        check("held pin", pin, s_pin);
        check("held oe", pin_oe, 8'hff);
        check("held keep", keep_level, s_keep);
        check("keep_en", {7'h00, keep_en}, 8'h01);
        check("plain hold", {7'h00, plain_hold}, 8'h00);
        // The build without the option keeps clocking and sees the high pin as data
        check("plain pin", plain_pin, xpin(pmc(pmc(mc, 8'h3c, 1'b1), 8'h3c, 1'b1), 8'h3c));
        u_sys.sleep(1'b0);
        ticks(`SH_WAKE_MAX_CYCLES);
        check("wake hold", {7'h00, hold}, 8'h00);
        check("wake oe", pin_oe, 8'h00);
        check("wake pin", pin & 8'h0f, s_pin & 8'h0f);
        u_sys.pulse();
        ticks(5);
        mc = nmc(mc, 8'h3c);
        check("resume pin", pin, xpin(mc, 8'h3c));
    endtask

    // A released output must not come back on during hold
    task automatic t_tristate();
        u_sys.sleep(1'b1);
        u_sys.drive(8'h3c, 1'b1);
        ticks(3);
        check("hiz oe", pin_oe, 8'h00);
        u_sys.sleep(1'b0);
        ticks(`SH_WAKE_MAX_CYCLES);
        check("wake oe on", pin_oe, 8'hff);
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        mc = 8'h00;
        repeat (3) @(posedge clock_i);
        rst_n_i <= 1'b1;
        t_reset();
        t_run();
        t_hold();
        t_tristate();
        tally_and_finish();
    end
endmodule
